// ### shared/rsc_pkg.sv
//
// Notes on behaviour
// [R1] Supply below threshold drives reset pin low and holds core until supply recovers.
// [R2] Power-on reset enables and selects the supply monitor; other resets keep its enable.
// [R3] An enabled supply monitor resets the device only when also selected.
// [R4] Software enables monitor, waits turn-on time, then selects it via bit 1.
// [R5] Selecting an unsettled monitor may reset the device.
// [R6] Release from a supply reset adds no power-on delay.
// [R7] Monitor control: bit 7 enable (default on), bit 6 status, bits 5-0 reserved.
// [R8] Low reset pin resets the device; pin flag bit 0 set on exit.
// [R9] Clock-loss one-shot resets the device after 100 us without a clock edge.
// [R10] Clock-loss flag bit 2 reads one only after a clock-loss reset.
// [R11] Writing bit 2 enables or disables the clock-loss detector.
// [R12] Clock-loss, comparator and watchdog resets leave the reset pin alone.
// [R13] Writing bit 5 selects or deselects the comparator as reset source.
// [R14] A selected comparator with low output puts the device in reset.
// [R15] Comparator flag bit 5 reads one only after a comparator reset.
// [R16] Software settles the comparator before selecting it as reset source.
// [R17] After every reset the watchdog runs enabled on the system clock over 12.
// [R18] Unserviced watchdog expiry resets the device and sets the watchdog flag.
// [R19] Software keeps the supply monitor enabled and selected during flash updates.
// [R20] Power-on exit sets power-on flag bit 1; other flags then indeterminate.
// [R21] All causes merge into one system reset; flags update only at release.
package rsc_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int unsigned RSC_CLK_PERIOD_NS   = 8;
  localparam int unsigned RSC_CLK_LOSS_US     = 100;
  localparam int unsigned RSC_CLK_LOSS_CYC    = RSC_CLK_LOSS_US * 1000 / RSC_CLK_PERIOD_NS;
  localparam int unsigned RSC_POR_DELAY_US    = 300;
  localparam int unsigned RSC_POR_DELAY_CYC   = RSC_POR_DELAY_US * 1000 / RSC_CLK_PERIOD_NS;
  localparam int unsigned RSC_MON_SETTLE_US   = 100;
  localparam int unsigned RSC_MON_SETTLE_CYC  = (RSC_MON_SETTLE_US * 1000 + RSC_CLK_PERIOD_NS - 1)
                                                / RSC_CLK_PERIOD_NS;
  localparam logic [3:0]  RSC_WDOG_DIV_LAST   = 4'hB;    // Divide by 12.
  localparam logic [15:0] RSC_WDOG_TICKS      = 16'hFFFF;
  localparam logic [15:0] RSC_MIN_HOLD_CYC    = 16'h0004;
  localparam logic [1:0]  RSC_PIN_BLANK_CYC   = 2'h3;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RSC_MON_CTRL_OFS   = 8'hFF;
  localparam logic [7:0] RSC_CAUSE_OFS      = 8'hEF;
  localparam logic [7:0] RSC_WDOG_CTRL_OFS  = 8'hD9;
  localparam int unsigned RSC_B_PIN         = 0;
  localparam int unsigned RSC_B_POWER       = 1;
  localparam int unsigned RSC_B_CLK_LOSS    = 2;
  localparam int unsigned RSC_B_WDOG        = 3;
  localparam int unsigned RSC_B_CMP         = 5;
  localparam int unsigned RSC_B_MON_EN      = 7;
  localparam int unsigned RSC_B_MON_STAT    = 6;
  localparam int unsigned RSC_B_WDOG_KICK   = 0;
  localparam int unsigned RSC_B_WDOG_EN     = 1;
  localparam logic [7:0] RSC_FLAGS_POWER    = 8'h02;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    RSC_ST_POWER = 2'h0,
    RSC_ST_RUN   = 2'h1,
    RSC_ST_HOLD  = 2'h3
  } rsc_state_e;

  typedef enum logic [2:0] {
    RSC_C_NONE, RSC_C_SUPPLY, RSC_C_PIN, RSC_C_CLK_LOSS, RSC_C_CMP, RSC_C_WDOG
  } rsc_cause_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rsc_bus_s;

  typedef struct packed {
    logic o;
    logic oe;
  } rsc_pin_s;

  typedef struct packed {
    rsc_state_e st;
    rsc_cause_e cause;
    logic       mon_en;
    logic       sel_sup;
    logic       sel_cmp;
    logic       loss_en;
    logic [7:0] fl;
    logic       wdog_en;
    logic [3:0] wdog_pre;
    logic [15:0] wdog_cnt;
    logic [15:0] loss_cnt;
    logic [15:0] dly;
    logic [15:0] settle;
    logic [1:0] blank;
    logic       sysrst_b;
    logic       pin_oe;
    logic [7:0] rdata;
    logic       sup_s1, sup_s2, pin_s1, pin_s2, cmp_s1, cmp_s2, clk_s1, clk_s2, clk_s3;
  } rsc_state_s;

endpackage

// ### hw/rsc_reset_source_controller.sv
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module rsc_reset_source_controller #(
  parameter logic [15:0] P_CLK_LOSS_CYC = 16'(rsc_pkg::RSC_CLK_LOSS_CYC),
  parameter logic [15:0] P_POR_DELAY    = 16'(rsc_pkg::RSC_POR_DELAY_CYC),
  parameter logic [15:0] P_MON_SETTLE   = 16'(rsc_pkg::RSC_MON_SETTLE_CYC),
  parameter logic [15:0] P_WDOG_TICKS   = rsc_pkg::RSC_WDOG_TICKS
) (
  input  wire logic             i_sys_clk,    // System clock, 125 MHz.
  input  wire logic             i_rst_b,      // Power-on reset, async, active low.
  input  wire rsc_pkg::rsc_bus_s i_bus,       // Register port request.
  output logic [7:0]            o_rdata,      // Read data, cycle after read strobe.
  input  wire logic             i_supply_ok,  // Supply above trip threshold.
  input  wire logic             i_rst_pin_b,  // Reset pin level, active low.
  input  wire logic             i_cmp_out,    // Comparator output, low trips.
  input  wire logic             i_mon_clk,    // Watched core clock.
  output logic                  o_mon_en,     // Supply monitor enable.
  output logic                  o_sys_rst_b,  // Core system reset, active low.
  output rsc_pkg::rsc_pin_s     o_rst_pin     // Reset pin drive, low when enabled.
);

  rsc_pkg::rsc_state_s r;
  rsc_pkg::rsc_state_s n;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Saturating counter step.
  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    sat_inc = (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction

  logic settling;
  logic sup_trip;
  logic pin_trip;
  logic loss_trip;
  logic cmp_trip;
  logic wdog_trip;
  logic run;
  logic wr_run;
  logic src_active;

  // Trip conditions seen by the sequencer.
  always_comb
  begin
    run       = (r.st == rsc_pkg::RSC_ST_RUN);
    wr_run    = i_bus.wr && run;
    settling  = (r.settle != 16'h0000);
    sup_trip  = r.mon_en && r.sel_sup && (!r.sup_s2 || settling);  // R1 R3 R5
    pin_trip  = !r.pin_s2 && (r.blank == 2'h0) && !r.pin_oe;      // R8
    loss_trip = r.loss_en && (r.loss_cnt >= P_CLK_LOSS_CYC);      // R9
    cmp_trip  = r.sel_cmp && !r.cmp_s2;                           // R14
    wdog_trip = r.wdog_en && (r.wdog_cnt >= P_WDOG_TICKS);        // R18
    case (r.cause)
      rsc_pkg::RSC_C_SUPPLY: src_active = sup_trip;
      rsc_pkg::RSC_C_PIN:    src_active = !r.pin_s2;
      rsc_pkg::RSC_C_CMP:    src_active = cmp_trip;
      default:               src_active = 1'h0;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  // Synchronisers, counters, register port and reset sequencer.
  always_comb
  begin
    n = r;
    n.sup_s1 = i_supply_ok;
    n.sup_s2 = r.sup_s1;
    n.pin_s1 = i_rst_pin_b;
    n.pin_s2 = r.pin_s1;
    n.cmp_s1 = i_cmp_out;
    n.cmp_s2 = r.cmp_s1;
    n.clk_s1 = i_mon_clk;
    n.clk_s2 = r.clk_s1;
    n.clk_s3 = r.clk_s2;
    n.settle = settling ? r.settle - 16'h0001 : 16'h0000;
    n.blank  = (r.blank != 2'h0) ? r.blank - 2'h1 : 2'h0;

    // One-shot: any edge of the watched clock restarts the count.
    if (!r.loss_en || !run || (r.clk_s2 != r.clk_s3))
      n.loss_cnt = 16'h0000;                                      // R9
    else
      n.loss_cnt = sat_inc(r.loss_cnt);

    // Watchdog ticks at one twelfth of the system clock.
    if (run && r.wdog_en)
    begin
      n.wdog_pre = (r.wdog_pre == rsc_pkg::RSC_WDOG_DIV_LAST) ? 4'h0 : r.wdog_pre + 4'h1;
      if (r.wdog_pre == rsc_pkg::RSC_WDOG_DIV_LAST)
        n.wdog_cnt = sat_inc(r.wdog_cnt);                         // R17
    end

    // Register reads answer in the next cycle only; unmapped reads give zero.
    n.rdata = 8'h00;
    if (i_bus.rd)
    begin
      case (i_bus.addr)
        rsc_pkg::RSC_MON_CTRL_OFS:
        begin
          n.rdata[rsc_pkg::RSC_B_MON_EN]   = r.mon_en;                     // R7
          n.rdata[rsc_pkg::RSC_B_MON_STAT] = r.mon_en && r.sup_s2 && !settling;
        end
        rsc_pkg::RSC_CAUSE_OFS:     n.rdata = r.fl;                  // R10 R15
        rsc_pkg::RSC_WDOG_CTRL_OFS: n.rdata[rsc_pkg::RSC_B_WDOG_EN] = r.wdog_en;
        default:                    n.rdata = 8'h00;
      endcase
    end

    // Writes act only while the core runs; the cause register writes enables.
    if (wr_run)
    begin
      case (i_bus.addr)
        rsc_pkg::RSC_MON_CTRL_OFS:
        begin
          n.mon_en = i_bus.wdata[rsc_pkg::RSC_B_MON_EN];                    // R7
          if (!r.mon_en && i_bus.wdata[rsc_pkg::RSC_B_MON_EN])
            n.settle = P_MON_SETTLE;                                        // R5
        end
        rsc_pkg::RSC_CAUSE_OFS:
        begin
          n.sel_sup = i_bus.wdata[rsc_pkg::RSC_B_POWER];                    // R3
          n.loss_en = i_bus.wdata[rsc_pkg::RSC_B_CLK_LOSS];                 // R11
          n.sel_cmp = i_bus.wdata[rsc_pkg::RSC_B_CMP];                      // R13
        end
        rsc_pkg::RSC_WDOG_CTRL_OFS:
        begin
          n.wdog_en = i_bus.wdata[rsc_pkg::RSC_B_WDOG_EN];
          if (i_bus.wdata[rsc_pkg::RSC_B_WDOG_KICK])
          begin
            n.wdog_cnt = 16'h0000;
            n.wdog_pre = 4'h0;
          end
        end
        default: n.mon_en = r.mon_en;
      endcase
    end

    // Reset sequencer.
    case (r.st)
      rsc_pkg::RSC_ST_POWER:
      begin
        n.sysrst_b = 1'h0;
        n.pin_oe   = 1'h1;                                          // R1
        n.dly      = sup_trip ? 16'h0000 : sat_inc(r.dly);
        if (r.dly >= P_POR_DELAY && !sup_trip)
        begin
          n.st       = rsc_pkg::RSC_ST_RUN;
          n.fl       = rsc_pkg::RSC_FLAGS_POWER;                    // R20
          n.sysrst_b = 1'h1;
          n.pin_oe   = 1'h0;
          n.blank    = rsc_pkg::RSC_PIN_BLANK_CYC;
        end
      end
      rsc_pkg::RSC_ST_RUN:
      begin
        n.dly = 16'h0000;
        if (sup_trip || pin_trip || loss_trip || cmp_trip || wdog_trip)
        begin
          n.st       = rsc_pkg::RSC_ST_HOLD;                        // R21
          n.sysrst_b = 1'h0;
          n.pin_oe   = sup_trip;                                    // R1 R12
          if (sup_trip)
            n.cause = rsc_pkg::RSC_C_SUPPLY;
          else if (pin_trip)
            n.cause = rsc_pkg::RSC_C_PIN;
          else if (loss_trip)
            n.cause = rsc_pkg::RSC_C_CLK_LOSS;
          else if (cmp_trip)
            n.cause = rsc_pkg::RSC_C_CMP;
          else
            n.cause = rsc_pkg::RSC_C_WDOG;
        end
      end
      rsc_pkg::RSC_ST_HOLD:
      begin
        n.dly = sat_inc(r.dly);
        if (sup_trip && r.cause != rsc_pkg::RSC_C_SUPPLY)
        begin
          n.cause  = rsc_pkg::RSC_C_SUPPLY;                         // R1
          n.pin_oe = 1'h1;
        end
        else if (!src_active &&
                 (r.cause == rsc_pkg::RSC_C_SUPPLY || r.dly >= rsc_pkg::RSC_MIN_HOLD_CYC))
        begin
          // Supply release skips the minimum hold and power-on delay.
          n.st       = rsc_pkg::RSC_ST_RUN;                         // R6 R21
          n.sysrst_b = 1'h1;
          n.pin_oe   = 1'h0;
          n.blank    = rsc_pkg::RSC_PIN_BLANK_CYC;
          n.cause    = rsc_pkg::RSC_C_NONE;
          n.wdog_en  = 1'h1;                                        // R17
          n.wdog_cnt = 16'h0000;
          n.wdog_pre = 4'h0;
          n.sel_cmp  = 1'h0;
          n.loss_en  = 1'h0;
          n.fl       = 8'h00;
          case (r.cause)
            rsc_pkg::RSC_C_SUPPLY:   n.fl = r.fl | rsc_pkg::RSC_FLAGS_POWER;  // R20
            rsc_pkg::RSC_C_PIN:      n.fl[rsc_pkg::RSC_B_PIN] = 1'h1;         // R8
            rsc_pkg::RSC_C_CLK_LOSS: n.fl[rsc_pkg::RSC_B_CLK_LOSS] = 1'h1;    // R10
            rsc_pkg::RSC_C_CMP:      n.fl[rsc_pkg::RSC_B_CMP] = 1'h1;         // R15
            default:                 n.fl[rsc_pkg::RSC_B_WDOG] = 1'h1;        // R18
          endcase
        end
      end
      default: n.st = rsc_pkg::RSC_ST_POWER;
    endcase
  end

  // State register; power-on enables and selects the supply monitor.
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      r          <= '0;
      r.st       <= rsc_pkg::RSC_ST_POWER;
      r.mon_en   <= 1'h1;                                           // R2
      r.sel_sup  <= 1'h1;                                           // R2
      r.fl       <= rsc_pkg::RSC_FLAGS_POWER;
      r.wdog_en  <= 1'h1;
      r.pin_oe   <= 1'h1;
      r.pin_s1   <= 1'h1;
      r.pin_s2   <= 1'h1;
      r.cmp_s1   <= 1'h1;
      r.cmp_s2   <= 1'h1;
    end
    else
      r <= n;
  end

  // Outputs straight from the state register; the pin output level is tied low.
  assign o_rdata     = r.rdata;
  assign o_mon_en    = r.mon_en;
  assign o_sys_rst_b = r.sysrst_b;
  assign o_rst_pin   = '{o: 1'h0, oe: r.pin_oe};

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  // All checks run on the system clock and sleep while power-on reset is held.
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_b);

  sequence s_sup_release;
    r.st == rsc_pkg::RSC_ST_HOLD && r.cause == rsc_pkg::RSC_C_SUPPLY && !sup_trip;
  endsequence
  sequence s_hold_done(rsc_pkg::rsc_cause_e c);
    r.st == rsc_pkg::RSC_ST_HOLD && r.cause == c && !src_active && !sup_trip
      && r.dly >= rsc_pkg::RSC_MIN_HOLD_CYC;
  endsequence

  chk_supply_pin_drive: assert property (run && sup_trip |=> !o_sys_rst_b && o_rst_pin.oe) // R1
    else $error("supply trip did not drive reset");
  // Supply monitor selection, enable retention, settling and release.
  chk_supply_unselected: assert property (run && !r.sel_sup && !pin_trip && !loss_trip // R3
    && !cmp_trip && !wdog_trip |=> o_sys_rst_b)
    else $error("reset without a selected source");
  chk_enable_kept: assert property (!run |=> $stable(r.mon_en)) // R2
    else $error("monitor enable changed by reset");
  chk_settle_trip: assert property (run && settling && r.mon_en && r.sel_sup // R5
    |=> !o_sys_rst_b)
    else $error("unsettled selected monitor did not reset");
  chk_supply_no_delay: assert property (s_sup_release |=> o_sys_rst_b // R6
    && r.fl[rsc_pkg::RSC_B_POWER])
    else $error("supply release delayed or flag missing");

  // Register port and pin-cause checks.
  chk_mon_ctrl_read: assert property (i_bus.rd && i_bus.addr == rsc_pkg::RSC_MON_CTRL_OFS // R7
    |=> o_rdata[5:0] == 6'h00 && o_rdata[rsc_pkg::RSC_B_MON_EN] == $past(r.mon_en))
    else $error("monitor control read wrong");
  chk_pin_flag: assert property (s_hold_done(rsc_pkg::RSC_C_PIN) // R8
    |=> o_sys_rst_b && r.fl == 8'h01)
    else $error("pin flag not set alone");

  // Clock-loss detector checks.
  chk_loss_timeout: assert property (run && r.loss_en && !(r.clk_s2 != r.clk_s3) // R9
    && r.loss_cnt == P_CLK_LOSS_CYC - 16'h0001 |=> ##1 !o_sys_rst_b)
    else $error("clock loss did not reset");
  // Each cause except supply leaves only its own flag set at release.
  chk_loss_flag: assert property (s_hold_done(rsc_pkg::RSC_C_CLK_LOSS) // R10
    |=> r.fl == 8'h04)
    else $error("clock-loss flag wrong");
  chk_loss_enable: assert property (wr_run && i_bus.addr == rsc_pkg::RSC_CAUSE_OFS // R11
    |=> r.loss_en == $past(i_bus.wdata[rsc_pkg::RSC_B_CLK_LOSS]) && r.fl == $past(r.fl))
    else $error("clock-loss enable write wrong");

  // Internal causes and comparator checks.
  chk_internal_no_pin: assert property (r.st == rsc_pkg::RSC_ST_HOLD // R12
    && r.cause inside {rsc_pkg::RSC_C_CLK_LOSS, rsc_pkg::RSC_C_CMP, rsc_pkg::RSC_C_WDOG}
    |-> !o_rst_pin.oe)
    else $error("internal reset drove the pin");
  chk_cmp_reset: assert property (run && !sup_trip && !pin_trip && !loss_trip && cmp_trip // R14
    |=> !o_sys_rst_b ##0 r.cause == rsc_pkg::RSC_C_CMP)
    else $error("comparator did not reset");
  chk_cmp_flag: assert property (s_hold_done(rsc_pkg::RSC_C_CMP) |=> r.fl == 8'h20) // R15
    else $error("comparator flag wrong");
  chk_wdog_restart: assert property (!run ##1 run |-> r.wdog_en && r.wdog_cnt == 16'h0000) // R17
    else $error("watchdog not restarted");
  chk_wdog_flag: assert property (s_hold_done(rsc_pkg::RSC_C_WDOG) |=> r.fl == 8'h08) // R18
    else $error("watchdog flag wrong");
  chk_flags_steady: assert property (run |=> !run || $stable(r.fl)) // R21
    else $error("flags changed outside release");

  // Power-on exit releases the core with only the power-on flag set.
  sequence s_power_exit;
    r.st == rsc_pkg::RSC_ST_POWER && r.dly >= P_POR_DELAY && !sup_trip;
  endsequence

  chk_power_exit: assert property (s_power_exit |=> run && o_sys_rst_b // R20
    && !o_rst_pin.oe && r.fl == rsc_pkg::RSC_FLAGS_POWER)
    else $error("power-on exit wrong");

  // The supply monitor stays enabled and selected throughout power-on.
  chk_power_defaults: assert property (r.st == rsc_pkg::RSC_ST_POWER // R2
    |-> r.mon_en && r.sel_sup)
    else $error("power-on monitor defaults wrong");

  // A write to the cause register sets the comparator select from bit 5.
  chk_cmp_select: assert property (wr_run && i_bus.addr == rsc_pkg::RSC_CAUSE_OFS // R13
    |=> r.sel_cmp == $past(i_bus.wdata[rsc_pkg::RSC_B_CMP]))
    else $error("comparator select write wrong");

  // A selected comparator that stays low keeps the core in reset.
  chk_cmp_hold: assert property (r.st == rsc_pkg::RSC_ST_HOLD // R14
    && r.cause == rsc_pkg::RSC_C_CMP && cmp_trip |=> !o_sys_rst_b)
    else $error("comparator hold released early");

  // Any synced edge of the watched clock restarts the one-shot.
  chk_loss_retrigger: assert property (run && r.loss_en && r.clk_s2 != r.clk_s3 // R9
    |=> r.loss_cnt == 16'h0000)
    else $error("clock-loss count not restarted");

  // The watchdog prescaler wraps after twelve system clocks.
  chk_wdog_divide: assert property (run && r.wdog_en // R17
    && r.wdog_pre == rsc_pkg::RSC_WDOG_DIV_LAST |=> r.wdog_pre == 4'h0)
    else $error("watchdog prescaler did not wrap");

endmodule
`default_nettype wire

// ### tb/rsc_far_side_model.sv
`timescale 1ns/1ns
`default_nettype none
module rsc_far_side_model (
  input  wire logic i_sys_clk,   // Bench clock.
  input  wire logic i_pull_low,  // External circuitry pulls the pin low.
  input  wire logic i_clk_run,   // Watched clock runs.
  input  wire logic i_supply_hi, // Supply above threshold.
  input  wire logic i_cmp_hi,    // Comparator inputs give a high output.
  input  wire logic i_pin_oe,    // Device drives the pin low.
  output logic      o_supply_ok, // Supply monitor level.
  output logic      o_pin_b,     // Reset pin wire level.
  output logic      o_cmp_out,   // Comparator output.
  output logic      o_mon_clk    // Watched clock.
);
  logic [1:0] div_r = 2'h0;
  logic       clk_r = 1'b0;

  // The pin has a pull-up, so it is low only while some party drives it.
  assign o_pin_b = ~(i_pin_oe | i_pull_low);
  // Supply level follows the bench command.
  assign o_supply_ok = i_supply_hi;
  // The comparator is enabled and settled, so its output never chatters.
  assign o_cmp_out = i_cmp_hi;
  assign o_mon_clk = clk_r;

  // The watched clock toggles every third cycle and stands still when stopped.
  always @(posedge i_sys_clk)
  begin
    div_r <= (div_r == 2'h2) ? 2'h0 : div_r + 2'h1;
    if (i_clk_run && div_r == 2'h2)
      clk_r <= ~clk_r;
  end
endmodule
`default_nettype wire

// ### tb/tb_rsc_reset_source_controller.sv
`timescale 1ns/1ns
`default_nettype none
module tb_rsc_reset_source_controller;
  logic                clk = 1'b0;
  logic                rst_b;
  rsc_pkg::rsc_bus_s   bus;
  logic [7:0]          rdata;
  logic                supply_ok, pin_b, cmp_out, mon_clk, mon_en, sys_rst_b;
  rsc_pkg::rsc_pin_s   pin;
  logic                pull_low, clk_run, supply_hi, cmp_hi;
  int                  num_errors = 0;
  int                  num_checks = 0;
  localparam logic [7:0] MON = rsc_pkg::RSC_MON_CTRL_OFS;
  localparam logic [7:0] CAU = rsc_pkg::RSC_CAUSE_OFS;
  localparam logic [7:0] WDG = rsc_pkg::RSC_WDOG_CTRL_OFS;

  // ---------------------------------------------------------------------------
  // Design, far side and clock
  // ---------------------------------------------------------------------------
  rsc_reset_source_controller #(
    .P_CLK_LOSS_CYC (16'h0028),
    .P_POR_DELAY    (16'h000A),
    .P_MON_SETTLE   (16'h0014),
    .P_WDOG_TICKS   (16'h0004)
  ) dut (
    .i_sys_clk   (clk),
    .i_rst_b     (rst_b),
    .i_bus       (bus),
    .o_rdata     (rdata),
    .i_supply_ok (supply_ok),
    .i_rst_pin_b (pin_b),
    .i_cmp_out   (cmp_out),
    .i_mon_clk   (mon_clk),
    .o_mon_en    (mon_en),
    .o_sys_rst_b (sys_rst_b),
    .o_rst_pin   (pin)
  );

  rsc_far_side_model far (
    .i_sys_clk   (clk),
    .i_pull_low  (pull_low),
    .i_clk_run   (clk_run),
    .i_supply_hi (supply_hi),
    .i_cmp_hi    (cmp_hi),
    .i_pin_oe    (pin.oe),
    .o_supply_ok (supply_ok),
    .o_pin_b     (pin_b),
    .o_cmp_out   (cmp_out),
    .o_mon_clk   (mon_clk)
  );

  // The clock inverts every half period of 4 ns.
  always #4 clk = ~clk;

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle register write.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
    #1;
  endtask

  // One-cycle register read; data are taken in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Reads a register and compares it with the expected value.
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  // Checks that no system reset occurs for n cycles.
  task automatic quiet(input int n);
    logic low;
    low = 1'b0;
    repeat (n)
    begin
      @(posedge clk);
      #1 low = low | (sys_rst_b !== 1'b1);
    end
    chk(8'(low), 8'h00);
  endtask

  // Waits a bounded time for the system reset to assert.
  task automatic fall(input int lim);
    int n;
    n = 0;
    while (sys_rst_b !== 1'b0 && n < lim)
    begin
      @(posedge clk);
      #1 n++;
    end
    chk(8'(sys_rst_b), 8'h00);
  endtask

  // Waits a bounded time for release, watching the pin drive meanwhile.
  task automatic rise(input int lim, input logic exp_oe);
    int n;
    logic bad;
    n = 0;
    bad = 1'b0;
    while (sys_rst_b !== 1'b1 && n < lim)
    begin
      bad = bad | (pin.oe !== exp_oe);
      @(posedge clk);
      #1 n++;
    end
    chk(8'({bad, sys_rst_b}), 8'h01);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic results;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  // Watchdog process cuts a hang short.
  initial
  begin
    #40000;
    num_errors++;
    results();
  end

  // Main sequence of reset scenarios.
  initial
  begin
    logic [7:0] d;
    rst_b = 1'b0;
    bus = '0;
    pull_low = 1'b0;
    clk_run = 1'b1;
    supply_hi = 1'b1;
    cmp_hi = 1'b1;
    repeat (20) @(posedge clk);
    #1 chk(8'({pin.o, sys_rst_b, pin.oe, mon_en}), 8'h03);
    @(posedge clk);
    rst_b <= 1'b1;
    rise(40, 1'b1);
    rc(CAU, 8'h02);
    rd(MON, d);
    chk(d & 8'hBF, 8'h80);
    rc(WDG, 8'h02);
    rc(8'h00, 8'h00);
    // Unserviced watchdog resets the core without touching the pin.
    fall(80);
    rise(20, 1'b0);
    rc(CAU, 8'h08);
    rc(WDG, 8'h02);
    wr(WDG, 8'h00);
    rc(MON, 8'hC0);
    // A disabled monitor survives a pin reset.
    wr(MON, 8'h00);
    wr(CAU, 8'h00);
    supply_hi <= 1'b0;
    quiet(10);
    supply_hi <= 1'b1;
    quiet(4);
    pull_low <= 1'b1;
    fall(6);
    repeat (6) @(posedge clk);
    pull_low <= 1'b0;
    rise(10, 1'b0);
    rc(CAU, 8'h01);
    chk(8'(mon_en), 8'h00);
    wr(WDG, 8'h00);
    // Re-arm the monitor: enable, wait turn-on time, then select.
    wr(MON, 8'h80);
    quiet(25);
    supply_hi <= 1'b0;
    quiet(10);
    supply_hi <= 1'b1;
    quiet(4);
    wr(CAU, 8'h02);
    quiet(10);
    // Comparator is ignored until selected, then trips.
    cmp_hi <= 1'b0;
    quiet(10);
    wr(CAU, 8'h22);
    fall(6);
    cmp_hi <= 1'b1;
    rise(12, 1'b0);
    rc(CAU, 8'h20);
    wr(WDG, 8'h00);
    // Clock loss trips only when enabled, after the set silence.
    clk_run <= 1'b0;
    quiet(60);
    clk_run <= 1'b1;
    wr(CAU, 8'h06);
    quiet(60);
    clk_run <= 1'b0;
    quiet(35);
    fall(15);
    clk_run <= 1'b1;
    rise(12, 1'b0);
    rc(CAU, 8'h04);
    wr(WDG, 8'h00);
    // Supply trip drives the pin and releases with no power-on delay.
    supply_hi <= 1'b0;
    fall(6);
    repeat (5) @(posedge clk);
    #1 chk(8'(pin.oe), 8'h01);
    supply_hi <= 1'b1;
    rise(8, 1'b1);
    rd(CAU, d);
    chk(d & 8'h02, 8'h02);
    chk(8'(mon_en), 8'h01);
    results();
  end
endmodule
`default_nettype wire
